// ==== core/scpm_pkg.sv ====
// Package: register map, field layout, reset values and mode codes
package scpm_pkg;
    // Register byte addresses on the Avalon-MM slave
    localparam logic [3:0] SCPM_ADDR_MODE_A = 4'h0;
    localparam logic [3:0] SCPM_ADDR_MODE_B = 4'h4;
    localparam logic [3:0] SCPM_ADDR_EVENT = 4'h8;
    // First mode register fields
    localparam int SCPM_FAST_SEL_BIT = 0;
    localparam int SCPM_IDLE_EN_BIT = 1;
    localparam int SCPM_FAST_RDY_BIT = 2;
    localparam int SCPM_SLOW_RDY_BIT = 3;
    localparam int SCPM_DIV_LSB = 5;
    // Second mode register fields
    localparam int SCPM_WDCFG_BIT = 0;
    localparam int SCPM_BADBO_BIT = 1;
    localparam int SCPM_BROWN_BIT = 2;
    localparam int SCPM_CTRLR_BIT = 3;
    localparam int SCPM_KEEP_BIT = 7;
    // Reset values
    localparam logic [2:0] SCPM_DIV_RST = 3'h0;
    localparam logic SCPM_IDLE_EN_RST = 1'b1;
    localparam logic SCPM_FAST_SEL_RST = 1'b1;
    localparam logic SCPM_KEEP_RST = 1'b0;
    // Divider select codes
    localparam logic [2:0] SCPM_DIV_SLOW1 = 3'h1;
    localparam logic [2:0] SCPM_DIV_64 = 3'h2;
    localparam logic [2:0] SCPM_DIV_2 = 3'h7;
    // Timing: cycles of slow clock before ready, ref cycles of fast settle
    localparam int SCPM_SLOW_RDY_CYC = 2;
    localparam int SCPM_FAST_SETTLE_CYC = 16;
    typedef enum logic [2:0] {
        SCPM_RUN, SCPM_DEEP_STOP, SCPM_STOP_WD, SCPM_IDLE_OFF, SCPM_IDLE_ON
    } scpm_mode_t;
endpackage

// ==== core/scpm_div_tap.sv ====
// Divider for the fast clock: one enable pulse every 2^n fast ticks
`timescale 1ns/1ns
`default_nettype none
module scpm_div_tap
    import scpm_pkg::*;
#(
    parameter int W = 6
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic tick,
    output logic [W-1:0] taps
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] taps;
    } scpm_div_st_t;
    scpm_div_st_t st;
    scpm_div_st_t next_st;
    // Counter clears while the fast oscillator is off, so taps stop too
    always_comb begin
        next_st = st;
        next_st.taps = '0;
        if (!run) begin
            next_st.cnt = '0;
        end else if (tick) begin
            next_st.cnt = st.cnt + W'(1);
            // Tap i fires when the low i+1 count bits are all ones
            for (int i = 0; i < W; i++) begin
                next_st.taps[i] = (st.cnt & W'((2 << i) - 1)) == W'((2 << i) - 1);
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign taps = st.taps;
endmodule // scpm_div_tap
`default_nettype wire

// ==== core/scpm_ctrl.sv ====
// Top: system clock source select, power modes and reset cause flags
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module scpm_ctrl
    import scpm_pkg::*;
#(
    parameter int FAST_SETTLE = SCPM_FAST_SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // CPU and wake-up
    input wire logic cpu_halt,
    input wire logic wake_up,
    input wire logic watchdog_enable,
    // Oscillator ticks (pins, synchronised here)
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    // Reset cause events from reset generator
    input wire logic ctrl_reg_reset_evt,
    input wire logic brownout_reset_evt,
    input wire logic watchdog_config_reset_evt,
    input wire logic brownout_level_bad,
    // Clock and power outputs
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic cpu_clk_en,
    output logic sysclk_tick,
    output logic periph_clk_en,
    output logic slow_wd_clk_en,
    output logic [5:0] fast_div_taps,
    output logic soft_reset_req,
    output scpm_mode_t power_mode
);
    typedef struct packed {
        logic [2:0] fsync;
        logic [2:0] ssync;
        logic [2:0] sysclk_divider_select;
        logic idle_on_halt_enable;
        logic fast_clock_select;
        logic idle_sysclk_keep;
        logic ctrl_reg_reset_flag;
        logic brownout_reset_flag;
        logic bad_brownout_config_flag;
        logic watchdog_config_reset_flag;
        logic fast_osc_ready;
        logic slow_osc_ready;
        logic [15:0] fast_cnt;
        logic [1:0] slow_cnt;
        scpm_mode_t mode;
        logic ack;
        logic [31:0] rdata;
        logic [5:0] div_cnt;
        logic tick;
        logic bad_seen;
    } scpm_st_t;
    scpm_st_t st;
    scpm_st_t next_st;
    logic fast_edge;
    logic slow_edge;
    logic use_slow;
    logic [5:0] taps;
    logic [7:0] mode_a_rd;
    logic [7:0] mode_b_rd;
    logic wr_a;
    logic wr_b;
    logic [7:0] wd;
    logic [15:0] settle_lim;

    // Rising edge seen while stage two is high and stage three still low
    assign fast_edge = st.fsync[1] && !st.fsync[2];
    assign slow_edge = st.ssync[1] && !st.ssync[2];
    assign settle_lim = 16'(FAST_SETTLE);
    // Slow source when fast select low and divider code 000 or 001
    assign use_slow = !st.fast_clock_select && (st.sysclk_divider_select <= SCPM_DIV_SLOW1);
    assign wd = avs_writedata[7:0];
    // Writes land only at the edge where waitrequest is seen low
    assign wr_a = avs_write && st.ack && avs_byteenable[0] && avs_address == SCPM_ADDR_MODE_A;
    assign wr_b = avs_write && st.ack && avs_byteenable[0] && avs_address == SCPM_ADDR_MODE_B;

    // Read images; unimplemented bits forced low
    always_comb begin
        mode_a_rd = '0;
        mode_a_rd[SCPM_DIV_LSB +: 3] = st.sysclk_divider_select;
        mode_a_rd[SCPM_SLOW_RDY_BIT] = st.slow_osc_ready;
        mode_a_rd[SCPM_FAST_RDY_BIT] = st.fast_osc_ready;
        mode_a_rd[SCPM_IDLE_EN_BIT] = st.idle_on_halt_enable;
        mode_a_rd[SCPM_FAST_SEL_BIT] = st.fast_clock_select;
        mode_b_rd = '0;
        mode_b_rd[SCPM_KEEP_BIT] = st.idle_sysclk_keep;
        mode_b_rd[SCPM_CTRLR_BIT] = st.ctrl_reg_reset_flag;
        mode_b_rd[SCPM_BROWN_BIT] = st.brownout_reset_flag;
        mode_b_rd[SCPM_BADBO_BIT] = st.bad_brownout_config_flag;
        mode_b_rd[SCPM_WDCFG_BIT] = st.watchdog_config_reset_flag;
    end

    // Main next-state logic
    always_comb begin
        next_st = st;
        next_st.fsync = {st.fsync[1:0], fast_rc_osc};
        next_st.ssync = {st.ssync[1:0], slow_rc_osc};
        next_st.tick = 1'b0;
        next_st.ack = 1'b0;

        // Bus: one wait cycle, answer on the second
        if ((avs_read || avs_write) && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = '0;
            if (avs_read) begin
                unique case (avs_address)
                    SCPM_ADDR_MODE_A: next_st.rdata = {24'h000000, mode_a_rd};
                    SCPM_ADDR_MODE_B: next_st.rdata = {24'h000000, mode_b_rd};
                    SCPM_ADDR_EVENT: next_st.rdata = {29'h00000000, st.mode};
                    default: next_st.rdata = '0; // Unmapped reads zero
                endcase
            end
        end
        if (wr_a) begin
            next_st.sysclk_divider_select = wd[SCPM_DIV_LSB +: 3];
            next_st.idle_on_halt_enable = wd[SCPM_IDLE_EN_BIT];
            next_st.fast_clock_select = wd[SCPM_FAST_SEL_BIT];
        end
        // Flags: software may only clear; hardware set wins
        if (wr_b) begin
            next_st.idle_sysclk_keep = wd[SCPM_KEEP_BIT];
            if (!wd[SCPM_CTRLR_BIT]) next_st.ctrl_reg_reset_flag = 1'b0;
            if (!wd[SCPM_BROWN_BIT]) next_st.brownout_reset_flag = 1'b0;
            if (!wd[SCPM_BADBO_BIT]) next_st.bad_brownout_config_flag = 1'b0;
            if (!wd[SCPM_WDCFG_BIT]) next_st.watchdog_config_reset_flag = 1'b0;
        end
        if (ctrl_reg_reset_evt) next_st.ctrl_reg_reset_flag = 1'b1;
        if (brownout_reset_evt) next_st.brownout_reset_flag = 1'b1;
        if (watchdog_config_reset_evt) next_st.watchdog_config_reset_flag = 1'b1;
        // Rising edge of the bad level only, so one soft reset per fault
        next_st.bad_seen = brownout_level_bad;
        if (brownout_level_bad) next_st.bad_brownout_config_flag = 1'b1;

        // Power mode: halt decides sleep or idle; wake returns to run
        unique case (st.mode)
            SCPM_RUN: begin
                if (cpu_halt) begin
                    if (!st.idle_on_halt_enable) begin
                        next_st.mode = watchdog_enable ? SCPM_STOP_WD : SCPM_DEEP_STOP;
                    end else begin
                        next_st.mode = st.idle_sysclk_keep ? SCPM_IDLE_ON : SCPM_IDLE_OFF;
                    end
                end
            end
            SCPM_DEEP_STOP, SCPM_STOP_WD, SCPM_IDLE_OFF, SCPM_IDLE_ON: begin
                if (wake_up) next_st.mode = SCPM_RUN;
            end
        endcase

        // Fast ready: cleared while oscillator off, set after settle count
        if (!fast_osc_enable) begin
            next_st.fast_cnt = '0;
            next_st.fast_osc_ready = 1'b0;
        end else if (st.fast_cnt >= settle_lim) begin
            next_st.fast_osc_ready = 1'b1;
        end else begin
            next_st.fast_cnt = st.fast_cnt + 16'h0001;
        end

        // Slow ready: low in deep stop, high after slow clock edges
        if (st.mode == SCPM_DEEP_STOP) begin
            next_st.slow_cnt = '0;
            next_st.slow_osc_ready = 1'b0;
        end else if (slow_edge && !st.slow_osc_ready) begin
            next_st.slow_cnt = st.slow_cnt + 2'h1;
            if (32'(st.slow_cnt) + 1 >= SCPM_SLOW_RDY_CYC) next_st.slow_osc_ready = 1'b1;
        end

        // System clock tick generation from selected source
        if (use_slow) begin
            next_st.div_cnt = '0;
            next_st.tick = slow_edge;
        end else if (fast_edge) begin
            next_st.div_cnt = st.div_cnt + 6'h01;
            if (st.fast_clock_select) begin
                next_st.tick = 1'b1;
            end else begin
                // Code 2 needs all six count bits, code 7 only the lowest one
                next_st.tick = &(st.div_cnt | ~(6'h3F >> (st.sysclk_divider_select - 3'h2)));
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.sysclk_divider_select <= SCPM_DIV_RST;
            st.idle_on_halt_enable <= SCPM_IDLE_EN_RST;
            st.fast_clock_select <= SCPM_FAST_SEL_RST;
            st.idle_sysclk_keep <= SCPM_KEEP_RST;
            st.mode <= SCPM_RUN;
        end else begin
            st <= next_st;
        end
    end

    // Fast oscillator off whenever slow is the system source
    always_comb begin
        fast_osc_enable = !use_slow;
        if (st.mode == SCPM_DEEP_STOP || st.mode == SCPM_STOP_WD || st.mode == SCPM_IDLE_OFF) begin
            fast_osc_enable = 1'b0;
        end
    end
    // Slow oscillator: stops in deep stop; kept in watchdog sleep while watchdog_enable is high
    assign slow_osc_enable = st.mode != SCPM_DEEP_STOP &&
        !(st.mode == SCPM_STOP_WD && !watchdog_enable);
    assign slow_wd_clk_en = slow_osc_enable;
    assign cpu_clk_en = st.mode == SCPM_RUN;
    // Peripheral clock runs in run mode and in both idle modes
    assign sysclk_tick = st.tick;
    assign periph_clk_en = st.mode == SCPM_RUN || st.mode == SCPM_IDLE_ON || st.mode == SCPM_IDLE_OFF;
    assign soft_reset_req = brownout_level_bad && !st.bad_seen;
    assign power_mode = st.mode;
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = (avs_read || avs_write) && !st.ack;

    // Divided fast taps stop with the fast oscillator
    scpm_div_tap #(.W(6)) u_taps (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .run(fast_osc_enable),
        .tick(fast_edge),
        .taps(taps)
    );
    assign fast_div_taps = taps;
endmodule // scpm_ctrl
`default_nettype wire

// ==== test/scpm_ctrl_checker.sv ====
// Checker: bus answer, power mode outputs and soft reset request
`timescale 1ns/1ns
`default_nettype none
module scpm_ctrl_checker
    import scpm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic cpu_halt,
    input wire logic brownout_level_bad,
    input wire logic fast_osc_enable,
    input wire logic slow_osc_enable,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic slow_wd_clk_en,
    input wire logic [5:0] fast_div_taps,
    input wire logic soft_reset_req,
    input wire scpm_mode_t power_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Bus answers one cycle after the request rises
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // Sync stages may still carry one edge, hence six cycles
    a_taps_stop: assert property (!fast_osc_enable [*6] |-> fast_div_taps == 6'h00)
        else $error("taps run with fast osc off");
    a_deep_stop: assert property (power_mode == SCPM_DEEP_STOP |-> !cpu_clk_en && !slow_osc_enable && !slow_wd_clk_en)
        else $error("deep stop clocks on");
    a_stop_wd: assert property (power_mode == SCPM_STOP_WD |-> !cpu_clk_en && slow_wd_clk_en)
        else $error("watchdog sleep clocks wrong");
    a_idle_off: assert property (power_mode == SCPM_IDLE_OFF |-> !cpu_clk_en && periph_clk_en && !fast_osc_enable)
        else $error("idle off clocks wrong");
    a_idle_on: assert property (power_mode == SCPM_IDLE_ON |-> !cpu_clk_en && periph_clk_en && slow_wd_clk_en)
        else $error("idle on clocks wrong");
    a_run_cpu: assert property (power_mode == SCPM_RUN |-> cpu_clk_en)
        else $error("cpu clock off in run");
    a_halt_enter: assert property (power_mode == SCPM_RUN && cpu_halt |-> ##[1:3] power_mode != SCPM_RUN)
        else $error("halt ignored");
    a_soft_reset: assert property ($rose(brownout_level_bad) |-> ##[0:3] soft_reset_req)
        else $error("no soft reset request");
endmodule // scpm_ctrl_checker
bind scpm_ctrl scpm_ctrl_checker scpm_ctrl_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_halt(cpu_halt), .brownout_level_bad(brownout_level_bad),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .slow_wd_clk_en(slow_wd_clk_en), .fast_div_taps(fast_div_taps),
    .soft_reset_req(soft_reset_req), .power_mode(power_mode));
`default_nettype wire

// ==== test/scpm_ctrl_tb.sv ====
// Testbench: registers, clock selection, power modes and reset flags
`timescale 1ns/1ns
`default_nettype none
module scpm_ctrl_tb
    import scpm_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic cpu_halt = 1'b0, wake_up = 1'b0, watchdog_enable = 1'b0;
    logic [3:0] avs_address = 4'h0, evt = 4'h0, be = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [7:0] div = 8'h00;
    logic avs_waitrequest, fast_osc_enable, slow_osc_enable, cpu_clk_en, sysclk_tick;
    logic periph_clk_en, slow_wd_clk_en, soft_reset_req;
    logic [5:0] fast_div_taps;
    scpm_mode_t power_mode;
    int n_fail = 0, checks = 0;
    always #20 ref_clk = ~ref_clk;
    // Oscillator stand-ins run only while enabled, as real ones would
    always @(posedge ref_clk) div <= div + 8'h01;
    scpm_ctrl #(.FAST_SETTLE(4)) scpm_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_halt(cpu_halt), .wake_up(wake_up),
        .watchdog_enable(watchdog_enable), .fast_rc_osc(div[1] & fast_osc_enable),
        .slow_rc_osc(div[4] & slow_osc_enable), .ctrl_reg_reset_evt(evt[3]),
        .brownout_reset_evt(evt[2]), .watchdog_config_reset_evt(evt[0]),
        .brownout_level_bad(evt[1]), .fast_osc_enable(fast_osc_enable),
        .slow_osc_enable(slow_osc_enable), .cpu_clk_en(cpu_clk_en), .sysclk_tick(sysclk_tick),
        .periph_clk_en(periph_clk_en), .slow_wd_clk_en(slow_wd_clk_en),
        .fast_div_taps(fast_div_taps), .soft_reset_req(soft_reset_req), .power_mode(power_mode));
    // Verdict and run end
    task end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus cycle; request held until waitrequest is sampled low at a rising edge
    task bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        if (avs_waitrequest !== 1'b0) chk("bus timeout", 32'h1, 32'h0);
        if (avs_waitrequest !== 1'b0) end_sim();
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Poll a ready flag of the first mode register
    task poll(input int b, input logic v);
        int i;
        for (i = 0; i < 60; i++) begin
            bus(SCPM_ADDR_MODE_A, 1'b0, 8'h00);
            if (q[b] === v) break;
        end
        chk("ready flag", q[b], v);
        if (q[b] !== v) end_sim();
    endtask
    task wait_mode(input scpm_mode_t m);
        int i;
        for (i = 0; i < 50 && power_mode !== m; i++) @(negedge ref_clk);
        chk("power_mode", power_mode, m);
        if (power_mode !== m) end_sim();
    endtask
    // Gap in cycles between two later system ticks; fast edge every 4 cycles
    task gap(input string nm, input int exp);
        int i, n, t;
        n = 0;
        t = 0;
        for (i = 0; i < 3000 && n < 3; i++) begin
            @(negedge ref_clk);
            if (sysclk_tick === 1'b1) begin
                n++;
                if (n == 3) chk(nm, i - t, exp);
                t = i;
            end
        end
        if (n < 3) chk("tick timeout", 32'h1, 32'h0);
        if (n < 3) end_sim();
    endtask
    task t_reset();
        bus(SCPM_ADDR_MODE_A, 1'b0, 8'h00);
        chk("mode a reset", q & 32'hFFFF_FFF3, 32'h3);
        bus(SCPM_ADDR_MODE_B, 1'b0, 8'h00);
        chk("mode b reset", q, 32'h0);
        poll(SCPM_FAST_RDY_BIT, 1'b1);
        bus(4'hC, 1'b1, 8'hFF);
        bus(4'hC, 1'b0, 8'h00);
        chk("unmapped", q, 32'h0);
        bus(SCPM_ADDR_MODE_A, 1'b1, 8'hFF);
        bus(SCPM_ADDR_MODE_A, 1'b0, 8'h00);
        chk("mode a bit4", q[4], 1'b0);
        // Write with the low byte lane off must leave the register alone
        be <= 4'hE;
        bus(SCPM_ADDR_MODE_A, 1'b1, 8'h00);
        be <= 4'hF;
        bus(SCPM_ADDR_MODE_A, 1'b0, 8'h00);
        chk("byteenable low", q & 32'hF3, 32'hE3);
    endtask
    task t_clock();
        int c;
        for (c = 2; c < 8; c++) begin
            bus(SCPM_ADDR_MODE_A, 1'b1, {c[2:0], 5'h02});
            gap("divider gap", 4 << (8 - c));
        end
        bus(SCPM_ADDR_MODE_A, 1'b1, 8'h43);
        gap("fast gap", 4);
        for (c = 0; c < 2; c++) begin
            bus(SCPM_ADDR_MODE_A, 1'b1, {c[2:0], 5'h02});
            repeat (8) @(posedge ref_clk);
            chk("fast osc off", fast_osc_enable, 1'b0);
            chk("taps off", fast_div_taps, 6'h00);
            poll(SCPM_SLOW_RDY_BIT, 1'b1);
        end
        bus(SCPM_ADDR_MODE_A, 1'b1, 8'h03);
        poll(SCPM_FAST_RDY_BIT, 1'b1);
    endtask
    // Halt into one mode, check it, then wake back to run
    task halt_case(input logic [7:0] a, input logic [7:0] b, input logic wd, input scpm_mode_t m);
        bus(SCPM_ADDR_MODE_A, 1'b1, a);
        bus(SCPM_ADDR_MODE_B, 1'b1, b);
        @(posedge ref_clk);
        watchdog_enable <= wd;
        cpu_halt <= 1'b1;
        @(posedge ref_clk);
        cpu_halt <= 1'b0;
        wait_mode(m);
        chk("cpu stopped", cpu_clk_en, 1'b0);
        chk("periph clock", periph_clk_en, m == SCPM_IDLE_OFF || m == SCPM_IDLE_ON);
        chk("slow osc", slow_osc_enable, m != SCPM_DEEP_STOP);
        bus(SCPM_ADDR_EVENT, 1'b0, 8'h00);
        chk("mode reg", q, m);
        if (m == SCPM_DEEP_STOP) poll(SCPM_SLOW_RDY_BIT, 1'b0);
        @(posedge ref_clk);
        wake_up <= 1'b1;
        @(posedge ref_clk);
        wake_up <= 1'b0;
        wait_mode(SCPM_RUN);
        chk("cpu running", cpu_clk_en, 1'b1);
        if (m == SCPM_DEEP_STOP) poll(SCPM_SLOW_RDY_BIT, 1'b1);
    endtask
    // Each reset cause: set by event, kept by writing 1, cleared by writing 0
    task t_flags();
        int i;
        bus(SCPM_ADDR_MODE_B, 1'b1, 8'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            evt <= 4'h1 << i;
            @(posedge ref_clk);
            if (i == 1) chk("soft reset", soft_reset_req, 1'b1);
            evt <= 4'h0;
            bus(SCPM_ADDR_MODE_B, 1'b0, 8'h00);
            chk("flag set", q, 32'h1 << i);
            bus(SCPM_ADDR_MODE_B, 1'b1, 8'hFF);
            bus(SCPM_ADDR_MODE_B, 1'b0, 8'h00);
            chk("flag kept", q, 32'h80 | (32'h1 << i));
            bus(SCPM_ADDR_MODE_B, 1'b1, 8'h00);
            bus(SCPM_ADDR_MODE_B, 1'b0, 8'h00);
            chk("flag cleared", q, 32'h0);
        end
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_clock();
        halt_case(8'h01, 8'h00, 1'b0, SCPM_DEEP_STOP);
        halt_case(8'h01, 8'h00, 1'b1, SCPM_STOP_WD);
        halt_case(8'h03, 8'h00, 1'b0, SCPM_IDLE_OFF);
        halt_case(8'h03, 8'h80, 1'b1, SCPM_IDLE_ON);
        t_flags();
        end_sim();
    end
endmodule // scpm_ctrl_tb
`default_nettype wire
